// [include/pci_bridge_pkg.sv]
// Purpose: shared constants of the pci highway bridge
// Assumes: 100 MHz core clock, 32-bit pci bus
// Notes:   identity values are arbitrary
package pci_bridge_pkg;
	typedef enum logic [1:0] {JOB_MEM, JOB_IO, JOB_CFG, JOB_DMA} job_kind_t;

	// bus commands
	localparam logic [3:0] CMD_IACK    = 4'h0;
	localparam logic [3:0] CMD_IO_RD   = 4'h2;
	localparam logic [3:0] CMD_IO_WR   = 4'h3;
	localparam logic [3:0] CMD_MEM_RD  = 4'h6;
	localparam logic [3:0] CMD_MEM_WR  = 4'h7;
	localparam logic [3:0] CMD_CFG_RD  = 4'ha;
	localparam logic [3:0] CMD_CFG_WR  = 4'hb;
	localparam logic [3:0] CMD_MEM_RDM = 4'hc;
	localparam logic [3:0] CMD_DAC     = 4'hd;
	localparam logic [3:0] CMD_MEM_RDL = 4'he;
	localparam logic [3:0] CMD_MWI     = 4'hf;

	// block and timing
	localparam int         BLOCK_BYTES = 64;
	localparam logic [4:0] BLOCK_WORDS = 5'(BLOCK_BYTES / 4);
	localparam int         CORE_MHZ    = 100;
	localparam int         PCI_MHZ     = 33;
	localparam int         CLK_DIV     = (CORE_MHZ + PCI_MHZ - 1) / PCI_MHZ;
	localparam logic [2:0] ABORT_CLKS  = 3'h5;

	// apertures and config space
	localparam int          APER_LSB    = 24;
	localparam logic [7:0]  XIO_TOP     = 8'hf0;
	localparam logic [5:0]  CFG_REG_ID  = 6'h00;
	localparam logic [5:0]  CFG_REG_BAR = 6'h04;
	// arbitrary identity value
	localparam logic [31:0] CFG_ID      = 32'h5a5a_0001;
	localparam logic [31:0] BAR_RESET   = 32'h0000_0000;
endpackage : pci_bridge_pkg

// [sim/pci_peer.sv]
// Purpose: far-side bus agent, target and simple initiator
// Assumes: only agent on the bus besides the bridge
// Notes:   released address lines show a changing pattern
`timescale 1ns/10ps
module pci_peer (
	// clock and reset
	input  wire logic        pci_clk_i,
	input  wire logic        rst_n_i,
	// bridge drive
	input  wire logic [31:0] ad_o,
	input  wire logic        ad_oe_o,
	input  wire logic [3:0]  cbe_o,
	input  wire logic        cbe_oe_o,
	input  wire logic        frame_n_o,
	input  wire logic        frame_oe_o,
	input  wire logic        irdy_n_o,
	input  wire logic        irdy_oe_o,
	input  wire logic        trdy_n_o,
	input  wire logic        trdy_oe_o,
	input  wire logic        devsel_n_o,
	input  wire logic        devsel_oe_o,
	input  wire logic        stop_n_o,
	input  wire logic        stop_oe_o,
	// resolved pins
	output wire logic [31:0] ad_i,
	output wire logic [3:0]  cbe_i,
	output wire logic        frame_n_i,
	output wire logic        irdy_n_i,
	output wire logic        trdy_n_i,
	output wire logic        devsel_n_i,
	output wire logic        stop_n_i,
	output wire logic        idsel_i
);
	logic [31:0] m_ad, ad_last, addr, last_addr, last_wdata;
	logic [3:0]  m_cbe, last_cmd;
	logic m_ad_oe = 1'b0, m_cbe_oe = 1'b0, m_frame_oe = 1'b0, m_irdy_oe = 1'b0;
	logic m_frame_n = 1'b1, m_irdy_n = 1'b1, m_idsel = 1'b0, init_busy = 1'b0;
	logic m_claim, m_trdy_n, m_devsel_n, busy, frame_q;
	logic [1:0]  dly;
	logic [1:0]  slow = 2'h0;
	int          words;

	// control lines pulled up when nobody drives
	assign ad_i = ad_oe_o ? ad_o : m_ad_oe ? m_ad : ~ad_last;
	assign cbe_i = cbe_oe_o ? cbe_o : m_cbe_oe ? m_cbe : ~ad_last[3:0];
	assign frame_n_i = frame_oe_o ? frame_n_o : m_frame_oe ? m_frame_n : 1'b1;
	assign irdy_n_i = irdy_oe_o ? irdy_n_o : m_irdy_oe ? m_irdy_n : 1'b1;
	assign trdy_n_i = trdy_oe_o ? trdy_n_o : m_claim ? m_trdy_n : 1'b1;
	assign devsel_n_i = devsel_oe_o ? devsel_n_o : m_claim ? m_devsel_n : 1'b1;
	assign stop_n_i = stop_oe_o ? stop_n_o : 1'b1;
	assign idsel_i = m_idsel;

	// target: claim, optional wait states, release one clock high
	always @(posedge pci_clk_i) begin
		ad_last <= ad_i;
		frame_q <= frame_n_i;
		if (!rst_n_i)
		begin
			busy <= 1'b0;
			m_claim <= 1'b0;
			m_ad_oe <= 1'b0;
		end
		else if (!busy)
		begin
			m_claim <= 1'b0;
			if (!frame_n_i && frame_q && !init_busy)
			begin
				busy <= 1'b1;
				m_claim <= 1'b1;
				m_devsel_n <= 1'b0;
				m_trdy_n <= 1'b1;
				last_cmd <= cbe_i;
				last_addr <= ad_i;
				addr <= ad_i;
				words <= 0;
				dly <= slow;
				m_ad <= {16'hd0d0, ad_i[15:0]};
				m_ad_oe <= !cbe_i[0];
			end
		end
		else if (!irdy_n_i && !trdy_n_i)
		begin
			words <= words + 1;
			addr <= addr + 32'h4;
			m_ad <= {16'hd0d0, addr[15:0] + 16'h4};
			last_wdata <= ad_i;
			m_trdy_n <= (slow != 2'h0) || frame_n_i;
			dly <= slow;
			if (frame_n_i)
			begin
				busy <= 1'b0;
				m_devsel_n <= 1'b1;
				m_ad_oe <= 1'b0;
			end
		end
		else if (dly != 2'h0)
			dly <= dly - 2'h1;
		else
			m_trdy_n <= 1'b0;
	end

	// single-phase initiator cycle toward the bridge
	task automatic init_cycle(input logic [3:0] c, input logic [31:0] a,
		input logic [31:0] d, input logic sel, output logic [31:0] q,
		output logic hit);
		int n;
		init_busy = 1'b1;
		@(posedge pci_clk_i);
		#1;
		m_frame_oe = 1'b1;
		m_frame_n = 1'b0;
		m_irdy_oe = 1'b1;
		m_ad_oe = 1'b1;
		m_ad = a;
		m_cbe_oe = 1'b1;
		m_cbe = c;
		m_idsel = sel;
		@(posedge pci_clk_i);
		#1;
		m_frame_n = 1'b1;
		m_irdy_n = 1'b0;
		m_cbe = 4'h0;
		m_idsel = 1'b0;
		m_ad = d;
		m_ad_oe = c[0];
		hit = 1'b0;
		n = 0;
		do
		begin
			@(posedge pci_clk_i);
			n++;
			if (!devsel_n_i)
				hit = 1'b1;
		end while (trdy_n_i && n < 8);
		q = ad_i;
		#1;
		m_irdy_n = 1'b1;
		m_frame_oe = 1'b0;
		m_ad_oe = 1'b0;
		m_cbe_oe = 1'b0;
		@(posedge pci_clk_i);
		#1;
		m_irdy_oe = 1'b0;
		init_busy = 1'b0;
	endtask : init_cycle
endmodule : pci_peer

// [sim/testbench.sv]
// Purpose: self-checking bench of the pci highway bridge
// Assumes: peer model is the only other bus agent
// Notes:   bus clock 80 ns, unrelated to the core clock
`timescale 1ns/10ps
module testbench;
	logic core_clk_i = 1'b0, pci_clk_i = 1'b0, rst_n_i = 1'b0;
	logic pci_clk_gen_en_i = 1'b1, mrm_dis_i = 1'b0, post_dis_i = 1'b0;
	logic mwi_en_i = 1'b0, job_req_i = 1'b0, job_write_i = 1'b0;
	logic icp_req_i = 1'b0, buf_we_i = 1'b0, hw_ack_i = 1'b0;
	logic [1:0]  job_kind_i = 2'h0;
	logic [4:0]  job_len_i = 5'h1;
	logic [3:0]  buf_idx_i = 4'h0, rd_idx_i = 4'h0;
	logic [31:0] job_addr_i = 32'h0, icp_addr_i = 32'h0, buf_wdata_i = 32'h0;
	logic [31:0] hw_rdata_i = 32'h0, hw_wd_seen = 32'h0;
	logic hw_we_seen = 1'b0, xio_seen = 1'b0, gnt_n_i;
	logic pci_clk_o, job_busy_o, job_done_o, job_fail_o, icp_ack_o, fill_bank_o;
	logic hw_req_o, hw_we_o, ad_oe_o, cbe_oe_o, frame_n_o, frame_oe_o, irdy_n_o;
	logic irdy_oe_o, trdy_n_o, trdy_oe_o, devsel_n_o, devsel_oe_o, stop_n_o;
	logic stop_oe_o, req_n_o, xio_sel_o;
	logic [31:0] rd_data_o, hw_addr_o, hw_wdata_o, ad_o, ad_i;
	logic [3:0]  cbe_o, cbe_i;
	logic frame_n_i, irdy_n_i, trdy_n_i, devsel_n_i, stop_n_i, idsel_i;
	int mismatches = 0;
	int checks_done = 0;

	assign gnt_n_i = req_n_o;

	pci_highway_bridge uut (.*);
	pci_peer peer (.*);

	initial forever #5 core_clk_i = ~core_clk_i;
	initial
	begin
		#3;
		forever #40 pci_clk_i = ~pci_clk_i;
	end

	always @(posedge core_clk_i) begin
		hw_ack_i <= hw_req_o && !hw_ack_i;
		hw_rdata_i <= ~hw_addr_o;
		if (hw_req_o && !hw_ack_i)
		begin
			hw_we_seen <= hw_we_o;
			hw_wd_seen <= hw_wdata_o;
		end
		if (xio_sel_o)
			xio_seen <= 1'b1;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic put_word(input logic [3:0] i, input logic [31:0] d);
		@(posedge core_clk_i);
		#1;
		buf_we_i = 1'b1;
		buf_idx_i = i;
		buf_wdata_i = d;
		@(posedge core_clk_i);
		#1;
		buf_we_i = 1'b0;
	endtask : put_word

	task automatic run_job(input logic [1:0] k, input logic w,
		input logic [31:0] a, input logic [4:0] len, output int cyc);
		@(posedge core_clk_i);
		#1;
		job_req_i = 1'b1;
		job_kind_i = k;
		job_write_i = w;
		job_addr_i = a;
		job_len_i = len;
		@(posedge core_clk_i);
		#1;
		job_req_i = 1'b0;
		cyc = 1;
		while (job_done_o !== 1'b1 && cyc < 4000)
		begin
			@(posedge core_clk_i);
			#1;
			cyc++;
		end
		check(32'(job_done_o), 32'h1);
		check(32'(job_fail_o), 32'h0);
	endtask : run_job

	task automatic t_clk();
		int   rises;
		logic prev;
		rises = 0;
		prev = pci_clk_o;
		repeat (40)
		begin
			@(posedge core_clk_i);
			#1;
			if (pci_clk_o && !prev)
				rises++;
			prev = pci_clk_o;
		end
		check(32'(rises), 32'd10);
	endtask : t_clk

	task automatic t_posted();
		int n;
		put_word(4'h0, 32'h1234_abcd);
		run_job(pci_bridge_pkg::JOB_MEM, 1'b1, 32'h1000_0040, 5'h1, n);
		check(32'(n), 32'd2);
		repeat (30) @(posedge pci_clk_i);
		check(32'(peer.last_cmd), 32'(pci_bridge_pkg::CMD_MEM_WR));
		check(peer.last_addr, 32'h1000_0040);
		check(peer.last_wdata, 32'h1234_abcd);
		check(32'(xio_seen), 32'h0);
	endtask : t_posted

	task automatic t_dma(input logic w, input logic m, input logic [3:0] cmd,
		input logic [4:0] len);
		int n;
		mrm_dis_i = m;
		mwi_en_i = w;
		peer.slow = 2'h2;
		run_job(pci_bridge_pkg::JOB_DMA, w, 32'h2000_0100, len, n);
		check(32'(peer.last_cmd), 32'(cmd));
		check(32'(peer.words), 32'(len));
		rd_idx_i = 4'h3;
		@(posedge core_clk_i);
		#1;
		if (!w)
			check(rd_data_o, 32'hd0d0_010c);
		peer.slow = 2'h0;
	endtask : t_dma

	task automatic t_single();
		int n;
		post_dis_i = 1'b1;
		run_job(pci_bridge_pkg::JOB_MEM, 1'b1, 32'hf000_0010, 5'h1, n);
		check(32'(n > 3), 32'h1);
		check(32'(xio_seen), 32'h1);
		run_job(pci_bridge_pkg::JOB_IO, 1'b1, 32'h0000_0300, 5'h1, n);
		check(32'(peer.last_cmd), 32'(pci_bridge_pkg::CMD_IO_WR));
		run_job(pci_bridge_pkg::JOB_CFG, 1'b0, 32'h0000_0804, 5'h1, n);
		check(32'(peer.last_cmd), 32'(pci_bridge_pkg::CMD_CFG_RD));
		post_dis_i = 1'b0;
	endtask : t_single

	task automatic t_inbound();
		logic [31:0] q;
		logic        hit;
		peer.init_cycle(pci_bridge_pkg::CMD_CFG_RD, 32'h0, 32'h0, 1'b1, q, hit);
		check(q, pci_bridge_pkg::CFG_ID);
		peer.init_cycle(pci_bridge_pkg::CMD_MEM_WR, 32'h0000_0080,
			32'hfeed_0001, 1'b0, q, hit);
		repeat (10) @(posedge pci_clk_i);
		check(hw_wd_seen, 32'hfeed_0001);
		check(32'(hw_we_seen), 32'h1);
		peer.init_cycle(pci_bridge_pkg::CMD_IACK, 32'h80, 32'h0, 1'b0, q, hit);
		check(32'(hit), 32'h0);
	endtask : t_inbound

	task automatic t_icp();
		int i;
		@(posedge core_clk_i);
		#1;
		mwi_en_i = 1'b0;
		icp_addr_i = 32'h3000_0000;
		icp_req_i = 1'b1;
		i = 0;
		while (icp_ack_o !== 1'b1 && i < 20)
		begin
			@(posedge core_clk_i);
			#1;
			i++;
		end
		icp_req_i = 1'b0;
		check(32'(icp_ack_o), 32'h1);
		repeat (40) @(posedge pci_clk_i);
		check(32'(peer.words), 32'd16);
		check(peer.last_addr, 32'h3000_0000);
	endtask : t_icp

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finish_test

	initial
	begin
		repeat (3) @(posedge pci_clk_i);
		@(posedge core_clk_i);
		#1;
		rst_n_i = 1'b1;
		t_clk();
		t_posted();
		t_dma(1'b0, 1'b0, pci_bridge_pkg::CMD_MEM_RDM, 5'h4);
		t_dma(1'b0, 1'b1, pci_bridge_pkg::CMD_MEM_RD, 5'h4);
		t_dma(1'b1, 1'b0, pci_bridge_pkg::CMD_MWI, 5'h10);
		t_single();
		t_inbound();
		t_icp();
		finish_test();
	end

	initial
	begin
		repeat (100000) @(posedge core_clk_i);
		mismatches++;
		finish_test();
	end
endmodule : testbench

// [verilog/pci_clk_gen.sv]
// Purpose: on-chip bus clock divider
// Assumes: strap is static around reset
// Notes:   strap caught once after reset release
`timescale 1ns/10ps
module pci_clk_gen (
	// clock and reset
	input  wire logic core_clk_i,
	input  wire logic rst_n_i,
	// boot strap
	input  wire logic strap_i,
	// generated clock
	output logic      pci_clk_o
);
	logic       strap_s1, strap_s2, en, seen;
	logic [2:0] cnt;

	always_ff @(posedge core_clk_i)
	begin
		strap_s1 <= strap_i;
		strap_s2 <= strap_s1;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			seen <= 1'b0;
			en   <= 1'b0;
		end
		else if (!seen)
		begin
			seen <= 1'b1;
			en   <= strap_s2;
		end
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i || !en)
		begin
			cnt       <= 3'h0;
			pci_clk_o <= 1'b0;
		end
		else
		begin
			cnt <= (cnt == 3'(pci_bridge_pkg::CLK_DIV - 1)) ? 3'h0 : cnt + 3'h1;
			pci_clk_o <= (cnt < 3'(pci_bridge_pkg::CLK_DIV / 2));
		end
	end

	property p_clk_off;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		!en |=> !pci_clk_o;
	endproperty
	a_clk_off: assert property (p_clk_off)
		else $error("bus clock runs while generator disabled");
endmodule : pci_clk_gen

// [verilog/pci_highway_bridge.sv]
// Purpose: bridge between highway and 32-bit pci bus
// Assumes: pci pins synchronous to pci_clk_i
// Notes:   one outbound job at a time, single target phase
`timescale 1ns/10ps
// Operation
// - highway cycles to pci space become bus cycles
// - bus cycles to local memory reach highway
// - only processor core and coprocessor start cycles
// - external initiators reach memory and control registers
// - some operations need explicit processor programming
// - burst and single; bursts cut to 64 bytes, rest not issued
// - inbound and outbound flows run concurrently
// - dma reads use read-multiple unless disabled
// - own bus clock generator, boot strap enabled
// - sideband select for simple 8-bit slaves
// - bus follows pci protocol revision 2.1
// - double-buffered bursts sustain full bus rate; only writes get two banks, reads share one buffer
// - posted writes, posting can be disabled
// - initiator can issue write-and-invalidate
// - target answers config and memory commands only; write-and-invalidate is not claimed
// - coprocessor dma yields to pending dma write
// - single-phase transactions keep issue order
module pci_highway_bridge (
	// clocks and reset
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        pci_clk_i,
	input  wire logic        pci_clk_gen_en_i,
	output logic             pci_clk_o,
	// configuration
	input  wire logic        mrm_dis_i,
	input  wire logic        post_dis_i,
	input  wire logic        mwi_en_i,
	// main processor core jobs
	input  wire logic        job_req_i,
	input  wire logic [1:0]  job_kind_i,
	input  wire logic        job_write_i,
	input  wire logic [31:0] job_addr_i,
	input  wire logic [4:0]  job_len_i,
	output logic             job_busy_o,
	output logic             job_done_o,
	output logic             job_fail_o,
	// image coprocessor blocks
	input  wire logic        icp_req_i,
	input  wire logic [31:0] icp_addr_i,
	output logic             icp_ack_o,
	// data buffers
	input  wire logic        buf_we_i,
	input  wire logic [3:0]  buf_idx_i,
	input  wire logic [31:0] buf_wdata_i,
	output logic             fill_bank_o,
	input  wire logic [3:0]  rd_idx_i,
	output logic [31:0]      rd_data_o,
	// highway master for inbound cycles
	output logic             hw_req_o,
	output logic             hw_we_o,
	output logic [31:0]      hw_addr_o,
	output logic [31:0]      hw_wdata_o,
	input  wire logic        hw_ack_i,
	input  wire logic [31:0] hw_rdata_i,
	// pci pins
	input  wire logic [31:0] ad_i,
	output logic [31:0]      ad_o,
	output logic             ad_oe_o,
	input  wire logic [3:0]  cbe_i,
	output logic [3:0]       cbe_o,
	output logic             cbe_oe_o,
	input  wire logic        frame_n_i,
	output logic             frame_n_o,
	output logic             frame_oe_o,
	input  wire logic        irdy_n_i,
	output logic             irdy_n_o,
	output logic             irdy_oe_o,
	input  wire logic        trdy_n_i,
	output logic             trdy_n_o,
	output logic             trdy_oe_o,
	input  wire logic        devsel_n_i,
	output logic             devsel_n_o,
	output logic             devsel_oe_o,
	input  wire logic        stop_n_i,
	output logic             stop_n_o,
	output logic             stop_oe_o,
	input  wire logic        idsel_i,
	input  wire logic        gnt_n_i,
	output logic             req_n_o,
	output logic             xio_sel_o
);
	typedef enum logic [2:0] {I_IDLE, I_REQ, I_ADDR, I_DATA, I_LAST,
		I_TURN} i_state_t;
	typedef enum logic [2:0] {T_IDLE, T_WAIT, T_CORE, T_DONE,
		T_TURN} t_state_t;

	function automatic logic [3:0] cmd_of(input pci_bridge_pkg::job_kind_t k,
		input logic wr, input logic mrm_dis, input logic mwi, input logic full);
		case (k)
			pci_bridge_pkg::JOB_IO:
				cmd_of = wr ? pci_bridge_pkg::CMD_IO_WR : pci_bridge_pkg::CMD_IO_RD;
			pci_bridge_pkg::JOB_CFG:
				cmd_of = wr ? pci_bridge_pkg::CMD_CFG_WR : pci_bridge_pkg::CMD_CFG_RD;
			pci_bridge_pkg::JOB_DMA:
				if (wr)
					cmd_of = (mwi && full) ? pci_bridge_pkg::CMD_MWI
						: pci_bridge_pkg::CMD_MEM_WR;
				else
					cmd_of = mrm_dis ? pci_bridge_pkg::CMD_MEM_RD
						: pci_bridge_pkg::CMD_MEM_RDM;
			default:
				cmd_of = wr ? pci_bridge_pkg::CMD_MEM_WR : pci_bridge_pkg::CMD_MEM_RD;
		endcase
	endfunction : cmd_of

	pci_bridge_pkg::job_kind_t j_kind;
	i_state_t    i_st;
	t_state_t    t_st;
	logic        j_pend, j_write, c_busy, c_tog, c_main, c_write, c_bank;
	logic        c_posted, prst1, prst, i_pend, i_fail, r_tog, t_tog, h_tog;
	logic        t_cfg, t_we, frame_q;
	logic [31:0] j_addr, c_addr, t_addr, t_wdata, t_rdata, bar, cfg_rd;
	logic [4:0]  j_len, c_len, i_idx;
	logic [3:0]  c_cmd;
	logic [2:0]  i_dv;
	logic [31:0] wr_buf [32];
	logic [31:0] rd_buf [16];
	logic        i_new, r_go, hw_go, t_resp;

	// core domain: job intake and arbitration
	wire gp_wr_pend = j_pend && j_kind == pci_bridge_pkg::JOB_DMA && j_write;
	wire pick_main  = !c_busy && j_pend;
	wire pick_icp   = !c_busy && !j_pend && icp_req_i && !icp_ack_o;
	wire posted     = j_write && j_kind == pci_bridge_pkg::JOB_MEM && !post_dis_i;

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
			j_pend <= 1'b0;
		else if (job_req_i && !job_busy_o)
		begin
			j_pend  <= 1'b1;
			j_kind  <= pci_bridge_pkg::job_kind_t'(job_kind_i);
			j_write <= job_write_i;
			j_addr  <= job_addr_i;
			j_len   <= job_len_i;
		end
		else if (pick_main)
			j_pend <= 1'b0;
	end

	// one channel, whole blocks: coprocessor waits behind main jobs
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			c_busy    <= 1'b0;
			c_tog     <= 1'b0;
			icp_ack_o <= 1'b0;
		end
		else
		begin
			icp_ack_o <= pick_icp;
			if (pick_main || pick_icp)
			begin
				c_busy   <= 1'b1;
				c_tog    <= ~c_tog;
				c_main   <= pick_main;
				c_posted <= pick_main && posted;
				c_bank   <= fill_bank_o;
				c_addr   <= pick_main ? j_addr : icp_addr_i;
				c_write  <= pick_main ? j_write : 1'b1;
				if (pick_icp)
					c_len <= pci_bridge_pkg::BLOCK_WORDS;
				else if (j_kind != pci_bridge_pkg::JOB_DMA)
					c_len <= 5'h01;
				else if (j_len == 5'h00 || j_len > pci_bridge_pkg::BLOCK_WORDS)
					c_len <= pci_bridge_pkg::BLOCK_WORDS;
				else
					c_len <= j_len;
				c_cmd <= pick_main ? cmd_of(j_kind, j_write, mrm_dis_i, mwi_en_i,
					j_len == pci_bridge_pkg::BLOCK_WORDS)
					: cmd_of(pci_bridge_pkg::JOB_DMA, 1'b1, mrm_dis_i, mwi_en_i, 1'b1);
			end
			else if (r_go)
				c_busy <= 1'b0;
		end
	end

	// write banks alternate so filling overlaps draining
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
			fill_bank_o <= 1'b0;
		else if ((pick_main && j_write) || pick_icp)
			fill_bank_o <= ~fill_bank_o;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (buf_we_i)
			wr_buf[{fill_bank_o, buf_idx_i}] <= buf_wdata_i;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			job_busy_o <= 1'b0;
			job_done_o <= 1'b0;
			job_fail_o <= 1'b0;
			rd_data_o  <= 32'h0000_0000;
		end
		else
		begin
			rd_data_o  <= rd_buf[rd_idx_i];
			job_done_o <= (pick_main && posted)
				|| (r_go && c_main && !c_posted);
			job_fail_o <= r_go && c_main && !c_posted && i_fail;
			if (job_req_i && !job_busy_o)
				job_busy_o <= 1'b1;
			else if ((pick_main && posted) || (r_go && c_main && !c_posted))
				job_busy_o <= 1'b0;
		end
	end

	// core domain: highway cycles for inbound bus accesses
	always_ff @(posedge core_clk_i)
	begin
		if (!rst_n_i)
		begin
			hw_req_o   <= 1'b0;
			hw_we_o    <= 1'b0;
			hw_addr_o  <= 32'h0000_0000;
			hw_wdata_o <= 32'h0000_0000;
			h_tog      <= 1'b0;
		end
		else if (hw_go)
		begin
			hw_req_o   <= 1'b1;
			hw_we_o    <= t_we;
			hw_addr_o  <= t_addr;
			hw_wdata_o <= t_wdata;
		end
		else if (hw_req_o && hw_ack_i)
		begin
			hw_req_o <= 1'b0;
			t_rdata  <= hw_rdata_i;
			h_tog    <= ~h_tog;
		end
	end

	// crossings
	tog_sync u_go    (.clk_i(pci_clk_i), .rst_n_i(prst), .tog_i(c_tog),
		.pulse_o(i_new));
	tog_sync u_rdone (.clk_i(core_clk_i), .rst_n_i(rst_n_i), .tog_i(r_tog),
		.pulse_o(r_go));
	tog_sync u_tgo   (.clk_i(core_clk_i), .rst_n_i(rst_n_i), .tog_i(t_tog),
		.pulse_o(hw_go));
	tog_sync u_tresp (.clk_i(pci_clk_i), .rst_n_i(prst), .tog_i(h_tog),
		.pulse_o(t_resp));
	pci_clk_gen u_clkgen (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
		.strap_i(pci_clk_gen_en_i), .pci_clk_o(pci_clk_o));

	always_ff @(posedge pci_clk_i)
	begin
		prst1 <= rst_n_i;
		prst  <= prst1;
	end

	// pci domain: initiator
	wire i_last  = (i_idx + 5'h01 == c_len);
	wire i_dp    = (i_st == I_DATA || i_st == I_LAST);
	wire i_xfer  = i_dp && !trdy_n_i && !devsel_n_i;
	wire i_stop  = i_dp && !stop_n_i && !devsel_n_i;
	wire i_abort = i_dp && devsel_n_i && i_dv == pci_bridge_pkg::ABORT_CLKS;
	wire i_grant = i_st == I_REQ && !gnt_n_i && frame_n_i && irdy_n_i;
	wire i_fin   = (i_xfer && i_last) || i_abort;
	wire i_quit  = i_fin || i_stop || (i_st == I_LAST && devsel_n_i);

	always_ff @(posedge pci_clk_i)
	begin
		if (!prst)
		begin
			i_st   <= I_IDLE;
			i_pend <= 1'b0;
			i_fail <= 1'b0;
			i_idx  <= 5'h00;
			i_dv   <= 3'h0;
			r_tog  <= 1'b0;
		end
		else
		begin
			if (i_new)
			begin
				i_pend <= 1'b1;
				i_idx  <= 5'h00;
			end
			if (i_xfer)
				i_idx <= i_idx + 5'h01;
			if (i_fin)
			begin
				i_pend <= 1'b0;
				i_fail <= i_abort;
				r_tog  <= ~r_tog;
			end
			case (i_st)
				I_IDLE: if (i_pend) i_st <= I_REQ;
				I_REQ: if (i_grant) i_st <= I_ADDR;
				I_ADDR:
				begin
					i_st <= I_DATA;
					i_dv <= 3'h0;
				end
				I_DATA:
				begin
					i_dv <= i_dv + 3'h1;
					if (i_fin || (i_stop && frame_n_o))
						i_st <= I_TURN;
					else if (i_stop)
						i_st <= I_LAST;
				end
				I_LAST: if (i_quit) i_st <= I_TURN;
				default: i_st <= I_IDLE;
			endcase
		end
	end

	always_ff @(posedge pci_clk_i)
	begin
		if (!prst)
		begin
			req_n_o    <= 1'b1;
			frame_n_o  <= 1'b1;
			frame_oe_o <= 1'b0;
			irdy_n_o   <= 1'b1;
			irdy_oe_o  <= 1'b0;
			cbe_o      <= 4'h0;
			cbe_oe_o   <= 1'b0;
			xio_sel_o  <= 1'b0;
		end
		else
		begin
			req_n_o <= !((i_st == I_IDLE && i_pend) || (i_st == I_REQ && !i_grant));
			if (i_grant)
			begin
				frame_n_o  <= 1'b0;
				frame_oe_o <= 1'b1;
				irdy_oe_o  <= 1'b1;
				cbe_o      <= c_cmd;
				cbe_oe_o   <= 1'b1;
				xio_sel_o  <= c_addr[31:24] == pci_bridge_pkg::XIO_TOP;
			end
			else if (i_st == I_ADDR)
			begin
				cbe_o     <= 4'h0;
				irdy_n_o  <= 1'b0;
				frame_n_o <= i_last;
			end
			else if (i_dp && i_quit && (i_st == I_LAST || frame_n_o))
				irdy_n_o <= 1'b1;
			else if (i_dp && (i_stop || (i_xfer && i_idx + 5'h02 == c_len)))
				frame_n_o <= 1'b1;
			else if (i_st == I_TURN)
			begin
				frame_oe_o <= 1'b0;
				irdy_oe_o  <= 1'b0;
				cbe_oe_o   <= 1'b0;
				xio_sel_o  <= 1'b0;
			end
		end
	end

	always_ff @(posedge pci_clk_i)
	begin
		if (i_xfer && !c_write)
			rd_buf[i_idx[3:0]] <= ad_i;
	end

	// pci domain: target, independent of the initiator
	wire is_mem  = cbe_i == pci_bridge_pkg::CMD_MEM_RD
		|| cbe_i == pci_bridge_pkg::CMD_MEM_WR
		|| cbe_i == pci_bridge_pkg::CMD_MEM_RDL
		|| cbe_i == pci_bridge_pkg::CMD_MEM_RDM;
	wire hit_mem = is_mem && ad_i[31:pci_bridge_pkg::APER_LSB]
		== bar[31:pci_bridge_pkg::APER_LSB];
	wire hit_cfg = idsel_i && ad_i[1:0] == 2'b00
		&& (cbe_i == pci_bridge_pkg::CMD_CFG_RD
		|| cbe_i == pci_bridge_pkg::CMD_CFG_WR);
	wire t_aph   = !frame_n_i && frame_q && !frame_oe_o;
	wire t_take  = t_st == T_IDLE && t_aph && (hit_mem || hit_cfg);
	wire t_ready = (t_st == T_WAIT && !irdy_n_i && t_cfg)
		|| (t_st == T_CORE && t_resp);

	always_comb
	begin
		if (t_addr[7:2] == pci_bridge_pkg::CFG_REG_ID)
			cfg_rd = pci_bridge_pkg::CFG_ID;
		else if (t_addr[7:2] == pci_bridge_pkg::CFG_REG_BAR)
			cfg_rd = bar;
		else
			cfg_rd = 32'h0000_0000;
	end

	always_ff @(posedge pci_clk_i)
	begin
		if (!prst)
		begin
			t_st    <= T_IDLE;
			t_tog   <= 1'b0;
			frame_q <= 1'b1;
			bar     <= pci_bridge_pkg::BAR_RESET;
		end
		else
		begin
			frame_q <= frame_n_i;
			case (t_st)
				T_IDLE:
					if (t_take)
					begin
						t_st   <= T_WAIT;
						t_cfg  <= hit_cfg;
						t_we   <= cbe_i[0];
						t_addr <= ad_i;
					end
				T_WAIT:
					if (!irdy_n_i)
					begin
						t_wdata <= ad_i;
						t_st    <= t_cfg ? T_DONE : T_CORE;
						if (!t_cfg)
							t_tog <= ~t_tog;
						else if (t_we && t_addr[7:2] == pci_bridge_pkg::CFG_REG_BAR)
							bar <= {ad_i[31:pci_bridge_pkg::APER_LSB],
								pci_bridge_pkg::APER_LSB'(0)};
					end
				T_CORE: if (t_resp) t_st <= T_DONE;
				T_DONE: t_st <= T_TURN;
				default: t_st <= T_IDLE;
			endcase
		end
	end

	always_ff @(posedge pci_clk_i)
	begin
		if (!prst)
		begin
			devsel_n_o  <= 1'b1;
			devsel_oe_o <= 1'b0;
			trdy_n_o    <= 1'b1;
			trdy_oe_o   <= 1'b0;
			stop_n_o    <= 1'b1;
			stop_oe_o   <= 1'b0;
		end
		else if (t_take)
		begin
			devsel_n_o  <= 1'b0;
			devsel_oe_o <= 1'b1;
			trdy_oe_o   <= 1'b1;
			stop_oe_o   <= 1'b1;
		end
		else if (t_ready)
		begin
			trdy_n_o <= 1'b0;
			stop_n_o <= 1'b0;
		end
		else if (t_st == T_DONE)
		begin
			devsel_n_o <= 1'b1;
			trdy_n_o   <= 1'b1;
			stop_n_o   <= 1'b1;
		end
		else if (t_st == T_TURN)
		begin
			devsel_oe_o <= 1'b0;
			trdy_oe_o   <= 1'b0;
			stop_oe_o   <= 1'b0;
		end
	end

	// shared address/data lines
	always_ff @(posedge pci_clk_i)
	begin
		if (!prst)
		begin
			ad_o    <= 32'h0000_0000;
			ad_oe_o <= 1'b0;
		end
		else if (i_grant)
		begin
			ad_o    <= c_addr + {25'h0, i_idx, 2'b00};
			ad_oe_o <= 1'b1;
		end
		else if (i_st == I_ADDR)
		begin
			ad_o    <= wr_buf[{c_bank, i_idx[3:0]}];
			ad_oe_o <= c_write;
		end
		else if (i_xfer && c_write)
			ad_o <= wr_buf[{c_bank, i_idx[3:0] + 4'h1}];
		else if (t_ready && !t_we)
		begin
			ad_o    <= t_cfg ? cfg_rd : t_rdata;
			ad_oe_o <= 1'b1;
		end
		else if (i_st == I_TURN || t_st == T_TURN)
			ad_oe_o <= 1'b0;
	end

	property p_icp_yield;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		icp_ack_o |-> !$past(gp_wr_pend);
	endproperty
	a_icp_yield: assert property (p_icp_yield)
		else $error("coprocessor block issued over pending dma write");

	property p_take_busy;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(job_req_i && !job_busy_o) |=> job_busy_o;
	endproperty
	a_take_busy: assert property (p_take_busy)
		else $error("job taken without busy");

	property p_mrm;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(pick_main && j_kind == pci_bridge_pkg::JOB_DMA && !j_write && !mrm_dis_i)
		|=> c_cmd == pci_bridge_pkg::CMD_MEM_RDM;
	endproperty
	a_mrm: assert property (p_mrm)
		else $error("dma read without read-multiple");

	property p_block;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		c_busy |-> (c_len != 5'h00 && c_len <= pci_bridge_pkg::BLOCK_WORDS);
	endproperty
	a_block: assert property (p_block)
		else $error("burst longer than one block");

	property p_post;
		@(posedge core_clk_i) disable iff (!rst_n_i)
		(pick_main && posted) |=> job_done_o ##1 !job_busy_o;
	endproperty
	a_post: assert property (p_post)
		else $error("posted write not completed at issue");

	property p_no_iack_dac;
		@(posedge pci_clk_i) disable iff (!prst)
		(frame_oe_o && !frame_n_o && $past(frame_n_o))
		|-> (cbe_o != pci_bridge_pkg::CMD_IACK && cbe_o != pci_bridge_pkg::CMD_DAC);
	endproperty
	a_no_iack_dac: assert property (p_no_iack_dac)
		else $error("forbidden command issued");

	property p_frame_end;
		@(posedge pci_clk_i) disable iff (!prst)
		(frame_oe_o && $rose(frame_n_o)) |-> !irdy_n_o;
	endproperty
	a_frame_end: assert property (p_frame_end)
		else $error("frame released without irdy");

	property p_ignore;
		@(posedge pci_clk_i) disable iff (!prst)
		(t_st == T_IDLE && t_aph && !hit_mem && !hit_cfg) |=> !devsel_oe_o[*2];
	endproperty
	a_ignore: assert property (p_ignore)
		else $error("target claimed unsupported command");
endmodule : pci_highway_bridge

// [verilog/tog_sync.sv]
// Purpose: toggle event crossing into a clock domain
// Assumes: source toggles no faster than three dest clocks
// Notes:   pulse lasts one dest clock
`timescale 1ns/10ps
module tog_sync (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// event
	input  wire logic tog_i,
	output logic      pulse_o
);
	logic s1, s2, s3;

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end
		else
		begin
			s1 <= tog_i;
			s2 <= s1;
			s3 <= s2;
		end
	end

	assign pulse_o = s2 ^ s3;
endmodule : tog_sync
